// ### tb/ffp_power_stage.sv
// Purpose: power stage and sense comparator model
// Assumes: drive sampled on mclk
// Notes: on_len of zero models a shorted sense pin
`timescale 1ns/10ps
module ffp_power_stage (
  input  wire logic        mclk,
  input  wire logic        gate_drive_output,
  input  wire logic [10:0] on_len,
  input  wire logic        short_on,
  input  wire logic        early,
  output logic             cs_limit,
  output logic             demag_det,
  output logic             aoc_raw
);
  logic [10:0] on_cnt = 11'h000;
  logic [3:0]  off_cnt = 4'hF;
  always @(posedge mclk) begin
    on_cnt  <= gate_drive_output ? on_cnt + 11'h001 : 11'h000;
    off_cnt <= gate_drive_output ? 4'h0 : (off_cnt == 4'hF ? off_cnt : off_cnt + 4'h1);
  end
  assign cs_limit  = gate_drive_output && on_len != 11'h000 && on_cnt >= on_len;
  // One valley per off period; none again until the next pulse
  assign demag_det = off_cnt == 4'h6;
  // Turn-on spike only, or a shorted winding for the whole pulse
  assign aoc_raw   = gate_drive_output & (short_on | (early & on_cnt == 11'h000));
endmodule // ffp_power_stage

// ### tb/tb.sv
// Purpose: self-checking bench for the fault sequencing block
// Assumes: power stage model answers each pulse
// Notes: waits are bounded; a spent bound counts as a mismatch
`timescale 1ns/10ps
module tb;
  import ffp_pkg::*;
  logic        mclk = 0, reset = 1, sov = 0, oov = 0, ot = 0, trec = 0;
  logic        armed = 0, ton = 0, sres = 0, line_rm = 0, dis = 0, req = 1;
  logic        short_on = 0, early = 0, aoc_raw, cs_limit, demag_det, gate, vt;
  logic [10:0] on_len = 11'h014;
  ffp_status_t st;
  int          mismatches = 0, check_count = 0;
  always #12.5 mclk = ~mclk;
  ffp_fault_ctrl ffp_fault_ctrl_i (.mclk(mclk), .reset(reset),
    .sense_async({aoc_raw, sov, oov, ot, trec, armed, ton, sres}),
    .line_removal(line_rm), .discharge_active(dis), .request_on(req),
    .cs_limit(cs_limit), .demag_det(demag_det), .gate_drive_output(gate),
    .valley_timeout(vt), .status(st));
  ffp_power_stage ffp_power_stage_i (.mclk(mclk), .gate_drive_output(gate),
    .on_len(on_len), .short_on(short_on), .early(early), .cs_limit(cs_limit),
    .demag_det(demag_det), .aoc_raw(aoc_raw));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %0h got %0h", n, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic run(input int n, output int k);
    logic p;
    k = 0;
    p = gate;
    repeat (n) begin
      @(negedge mclk);
      if (gate === 1'b1 && p !== 1'b1) k++;
      p = gate;
    end
  endtask
  task automatic wait_gate(input logic v);
    for (int i = 0; i < 400 && gate !== v; i++) cyc(1);
    if (gate !== v) begin
      chk("gate wait", v, gate);
      finish_test();
    end
  endtask
  // Output overvoltage is changed while on, so the whole next off period sees it
  task automatic pulse(input logic s, input logic e, input logic ov);
    short_on = s;
    early = e;
    wait_gate(1);
    oov = ov;
    wait_gate(0);
  endtask
  task automatic start();
    short_on = 0; early = 0; oov = 0;
    sres = 1; cyc(4); sres = 0; dis = 0; line_rm = 0;
    ton = 1; cyc(4); ton = 0;
  endtask
  task automatic t_aoc();
    int k;
    start();
    repeat (5) pulse(0, 1, 0);
    chk("early trip", 0, st.latched);
    repeat (3) pulse(1, 0, 0);
    pulse(0, 0, 0);
    repeat (3) pulse(1, 0, 0);
    chk("broken aoc run", 0, st.latched);
    pulse(1, 0, 0);
    cyc(2);
    chk("aoc latch", 2'h3, {st.latched, st.aoc_latch});
    short_on = 0; ton = 1; run(300, k); ton = 0;
    chk("latched pulses", 0, k);
    dis = 1; cyc(4);
    chk("discharge clear", 0, st.latched);
  endtask
  task automatic t_maxon();
    int n;
    start();
    on_len = 11'h000;
    wait_gate(1);
    n = 0;
    while (gate === 1'b1 && n < 2000) begin
      cyc(1);
      n++;
    end
    chk("on time", MAX_ON_CYC, n);
    on_len = 11'h014;
  endtask
  task automatic t_armed();
    int v, g;
    start();
    armed = 1; v = 0; g = 0;
    // A pulse already running when arming arrives is allowed to finish
    wait_gate(0);
    cyc(3);
    for (int i = 0; i < 400; i++) begin
      cyc(1);
      if (vt === 1'b1) v++;
      if (gate !== 1'b0) g++;
    end
    chk("armed timeout", 0, v);
    chk("armed drive", 0, g);
    armed = 0;
    for (int i = 0; i < 300 && vt !== 1'b1; i++) cyc(1);
    chk("valley timeout", 1, vt);
    wait_gate(1);
  endtask
  task automatic t_sov();
    start();
    wait_gate(1);
    sov = 1; cyc(3);
    chk("sov drive", 0, gate);
    chk("sov latch", 2'h3, {st.latched, st.supply_ov_latch});
    sov = 0;
  endtask
  task automatic t_oov();
    int k;
    start();
    pulse(0, 0, 1); pulse(0, 0, 1); pulse(0, 0, 0); pulse(0, 0, 1); pulse(0, 0, 1);
    chk("broken ovp run", 0, st.latched);
    pulse(0, 0, 1);
    run(400, k);
    chk("ovp pulses", 0, k);
    chk("ovp latch", 1, st.out_ov_latch);
    reset = 1; cyc(3); reset = 0;
    chk("reset status", 0, {st, gate});
  endtask
  task automatic t_thermal();
    int k;
    start();
    wait_gate(1);
    ot = 1; cyc(4);
    chk("otp drive", 0, gate);
    chk("otp state", 2'h1, {st.latched, st.thermal});
    ot = 0; ton = 1; cyc(4); ton = 0;
    chk("no hysteresis", 1, st.thermal);
    trec = 1; ton = 1; cyc(4); ton = 0;
    chk("otp recovered", 0, st.thermal);
    ton = 1; cyc(4); ton = 0; run(400, k);
    chk("restart", 1, k != 0);
    ot = 1; cyc(4); ot = 0; trec = 0; line_rm = 1; cyc(4); line_rm = 0;
    chk("line removal", 0, st.thermal);
    ton = 1; cyc(4); ton = 0; wait_gate(1);
    ot = 1; cyc(4);
    chk("thermal again", 1, st.thermal);
    ot = 0; sres = 1; cyc(4); sres = 0;
    chk("supply reset", 0, st.thermal);
  endtask
  initial begin
    cyc(8);
    reset = 0;
    t_aoc();
    t_maxon();
    t_armed();
    t_sov();
    t_oov();
    t_thermal();
    finish_test();
  end
endmodule // tb

// ### verilog/ffp_fault_ctrl.sv
// Purpose: fault sequencing and gate drive timing of a flyback controller
// Assumes: request_on asks for a pulse, cs_limit ends it, demag_det marks valley
// Notes: latched state leaves only through reset inputs, never by itself
`timescale 1ns/10ps
module ffp_fault_ctrl
  import ffp_pkg::*;
(
  input  wire logic  mclk,
  input  wire logic  reset,
  input  ffp_sense_t sense_async,
  input  wire logic  line_removal,
  input  wire logic  discharge_active,
  input  wire logic  request_on,
  input  wire logic  cs_limit,
  input  wire logic  demag_det,
  output logic       gate_drive_output,
  output logic       valley_timeout,
  output ffp_status_t status
);
  ffp_sense_t sense;
  logic [NUM_SYNC-1:0] raw_bits;
  logic [NUM_SYNC-1:0] sync_bits;
  logic                line_sync;
  logic                dis_sync;

  assign raw_bits = sense_async;

  // Comparators are asynchronous; every one crosses through two flops
  for (genvar i = 0; i < NUM_SYNC; i++) begin : g_sync
    ffp_sync u_sync (.mclk(mclk), .reset(reset), .async_in(raw_bits[i]),
                     .sync_out(sync_bits[i]));
  end
  ffp_sync u_line (.mclk(mclk), .reset(reset), .async_in(line_removal),
                   .sync_out(line_sync));
  ffp_sync u_dis  (.mclk(mclk), .reset(reset), .async_in(discharge_active),
                   .sync_out(dis_sync));
  assign sense = sync_bits;

  ffp_state_t        state_reg, state_next;
  logic [TIMER_W-1:0] on_timer_reg, on_timer_next;
  logic [7:0]        vt_timer_reg, vt_timer_next;
  logic [2:0]        aoc_cnt_reg, aoc_cnt_next;
  logic [1:0]        ov_cnt_reg, ov_cnt_next;
  logic              aoc_seen_reg, aoc_seen_next;
  logic              ov_seen_reg, ov_seen_next;
  logic              vt_reg, vt_next;
  ffp_status_t       stat_reg, stat_next;
  logic              blanked;
  logic              pulse_end;
  logic              clear_req;

  assign blanked   = on_timer_reg < TIMER_W'(SHORT_BLANK_CYC);
  assign clear_req = sense.supply_reset || dis_sync;
  assign pulse_end = (state_reg == FFP_ON) &&
                     (cs_limit || on_timer_reg >= TIMER_W'(MAX_ON_CYC - 1));

  always_comb begin
    state_next    = state_reg;
    on_timer_next = on_timer_reg;
    vt_timer_next = vt_timer_reg;
    aoc_cnt_next  = aoc_cnt_reg;
    ov_cnt_next   = ov_cnt_reg;
    aoc_seen_next = aoc_seen_reg;
    ov_seen_next  = ov_seen_reg;
    vt_next       = 1'b0;
    stat_next     = stat_reg;
    unique case (state_reg)
      FFP_OFF: begin
        // Only a fresh turn-on with over-temperature and supply overvoltage gone starts switching
        if (sense.supply_turn_on && !sense.over_temp && !sense.supply_ov_trip) begin
          state_next    = FFP_DEMAG;
          vt_timer_next = '0;
        end
      end
      FFP_ON: begin
        on_timer_next = on_timer_reg + 1'b1;
        if (sense.aoc_trip && !blanked) begin
          aoc_seen_next = 1'b1;
        end
        if (pulse_end) begin
          state_next    = FFP_DEMAG;
          vt_timer_next = '0;
          ov_seen_next  = 1'b0;
          if (aoc_seen_next) begin
            aoc_cnt_next = aoc_cnt_reg + 1'b1;
          end else begin
            aoc_cnt_next = '0;
          end
          if (aoc_seen_next && aoc_cnt_reg == AOC_LIMIT - 3'h1) begin
            state_next       = FFP_LATCHED;
            stat_next.aoc_latch = 1'b1;
          end
        end
      end
      FFP_DEMAG: begin
        if (sense.out_ov_trip) begin
          ov_seen_next = 1'b1;
        end
        // Valley timer held at zero while demag input is armed
        if (sense.demag_armed) begin
          vt_timer_next = '0;
        end else if (vt_timer_reg != 8'(VALLEY_TIMEOUT_CYC)) begin
          vt_timer_next = vt_timer_reg + 1'b1;
        end
        vt_next = !sense.demag_armed && vt_timer_reg == 8'(VALLEY_TIMEOUT_CYC);
        if ((demag_det || vt_next) && request_on && !sense.demag_armed) begin
          state_next    = FFP_ON;
          on_timer_next = '0;
          aoc_seen_next = 1'b0;
          ov_cnt_next   = ov_seen_reg ? ov_cnt_reg + 1'b1 : 2'h0;
          if (ov_seen_reg && ov_cnt_reg == OUT_OV_LIMIT - 2'h1) begin
            state_next          = FFP_LATCHED;
            stat_next.out_ov_latch = 1'b1;
          end
        end
      end
      FFP_LATCHED: begin
        if (clear_req) begin
          state_next = FFP_OFF;
          stat_next  = '0;
          aoc_cnt_next = '0;
          ov_cnt_next  = '0;
        end
      end
      FFP_THERMAL: begin
        if (sense.supply_reset || line_sync) begin
          state_next = FFP_OFF;
          stat_next.thermal = 1'b0;
        end else if (sense.temp_recovered && sense.supply_turn_on &&
                     !sense.over_temp) begin
          state_next = FFP_OFF;
          stat_next.thermal = 1'b0;
        end
      end
    endcase
    // Armed demag clears the valley timer to zero in every state, so a pulse never inherits a stale count
    if (sense.demag_armed) begin
      vt_timer_next = '0;
    end
    // Latching faults outrank thermal, checked from any running state
    if (state_reg != FFP_LATCHED && sense.supply_ov_trip) begin
      state_next = FFP_LATCHED;
      stat_next.supply_ov_latch = 1'b1;
    end else if ((state_reg == FFP_ON || state_reg == FFP_DEMAG) && sense.over_temp
                 && state_next != FFP_LATCHED) begin
      state_next = FFP_THERMAL;
      stat_next.thermal = 1'b1;
    end
    stat_next.latched = (state_next == FFP_LATCHED);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg    <= FFP_OFF;
      on_timer_reg <= '0;
      vt_timer_reg <= '0;
      aoc_cnt_reg  <= '0;
      ov_cnt_reg   <= '0;
      aoc_seen_reg <= 1'b0;
      ov_seen_reg  <= 1'b0;
      vt_reg       <= 1'b0;
      stat_reg     <= '0;
    end else begin
      state_reg    <= state_next;
      on_timer_reg <= on_timer_next;
      vt_timer_reg <= vt_timer_next;
      aoc_cnt_reg  <= aoc_cnt_next;
      ov_cnt_reg   <= ov_cnt_next;
      aoc_seen_reg <= aoc_seen_next;
      ov_seen_reg  <= ov_seen_next;
      vt_reg       <= vt_next;
      stat_reg     <= stat_next;
    end
  end

  // Drive is gated combinationally so a supply overvoltage trip cuts it at once
  assign gate_drive_output = (state_reg == FFP_ON) && !sense.supply_ov_trip;
  assign valley_timeout    = vt_reg;
  assign status            = stat_reg;

  // Pulse timing and blanking
  chk_max_on_time: assert property (@(posedge mclk) disable iff (reset)
    (state_reg == FFP_ON && on_timer_reg == TIMER_W'(MAX_ON_CYC - 1))
    |=> state_reg != FFP_ON)
    else $error("on-time exceeded maximum");
  chk_on_timer_step: assert property (@(posedge mclk) disable iff (reset)
    (state_reg == FFP_ON && state_next == FFP_ON)
    |=> on_timer_reg == $past(on_timer_reg) + TIMER_W'(1))
    else $error("on-time counter skipped");
  chk_aoc_blank: assert property (@(posedge mclk) disable iff (reset)
    (state_reg == FFP_ON && on_timer_reg <= TIMER_W'(SHORT_BLANK_CYC))
    |-> !aoc_seen_reg)
    else $error("aoc seen during blanking");
  chk_blank_start: assert property (@(posedge mclk) disable iff (reset)
    (state_reg == FFP_DEMAG && state_next == FFP_ON)
    |=> on_timer_reg == TIMER_W'(0) && !aoc_seen_reg)
    else $error("pulse started with stale blanking state");
  // Abnormal overcurrent counting
  chk_aoc_clear: assert property (@(posedge mclk) disable iff (reset)
    (pulse_end && !aoc_seen_next)
    |=> aoc_cnt_reg == 3'h0)
    else $error("aoc counter not cleared by clean pulse");
  chk_aoc_latch: assert property (@(posedge mclk) disable iff (reset)
    (pulse_end && aoc_seen_next && aoc_cnt_reg == 3'h3)
    |=> state_reg == FFP_LATCHED)
    else $error("four aoc pulses did not latch");
  chk_aoc_step: assert property (@(posedge mclk) disable iff (reset)
    (pulse_end && aoc_seen_next && aoc_cnt_reg != 3'h3)
    |=> aoc_cnt_reg == $past(aoc_cnt_reg) + 3'h1)
    else $error("aoc counter did not advance");
  // Valley timeout and demag arming
  chk_vt_frozen: assert property (@(posedge mclk) disable iff (reset)
    sense.demag_armed
    |=> vt_timer_reg == 8'h00 && !valley_timeout)
    else $error("valley timeout ran while armed");
  chk_vt_pulse: assert property (@(posedge mclk) disable iff (reset)
    valley_timeout
    |-> !$past(sense.demag_armed))
    else $error("valley timeout fired while armed");
  chk_no_pulse_armed: assert property (@(posedge mclk) disable iff (reset)
    (state_reg == FFP_DEMAG && sense.demag_armed)
    |=> state_reg != FFP_ON)
    else $error("pulse issued while demag armed");
  chk_on_entry: assert property (@(posedge mclk) disable iff (reset)
    (state_reg == FFP_DEMAG && state_next == FFP_ON)
    |-> (demag_det || vt_next) && !sense.demag_armed)
    else $error("pulse started without valley");
  // Latching faults
  chk_supply_ov_latch: assert property (@(posedge mclk) disable iff (reset)
    (sense.supply_ov_trip && !(state_reg == FFP_LATCHED && clear_req))
    |-> !gate_drive_output ##1 state_reg == FFP_LATCHED)
    else $error("supply overvoltage did not latch");
  chk_thermal_latch: assert property (@(posedge mclk) disable iff (reset)
    (state_reg == FFP_THERMAL && sense.supply_ov_trip)
    |=> state_reg == FFP_LATCHED)
    else $error("supply overvoltage ignored in thermal");
  chk_ov_latch: assert property (@(posedge mclk) disable iff (reset)
    (state_reg == FFP_DEMAG && ov_seen_reg && ov_cnt_reg == 2'h2 && (demag_det || vt_next) &&
     request_on && !sense.demag_armed)
    |=> state_reg == FFP_LATCHED)
    else $error("third output overvoltage did not latch");
  chk_ov_break: assert property (@(posedge mclk) disable iff (reset)
    (state_reg == FFP_DEMAG && state_next == FFP_ON && !ov_seen_reg)
    |=> ov_cnt_reg == 2'h0)
    else $error("clean cycle did not break overvoltage run");
  chk_ov_count: assert property (@(posedge mclk) disable iff (reset)
    (state_reg == FFP_DEMAG && state_next == FFP_ON && ov_seen_reg)
    |=> ov_cnt_reg == $past(ov_cnt_reg) + 2'h1)
    else $error("overvoltage counter did not advance");
  // Thermal shutdown and restart
  chk_thermal_enter: assert property (@(posedge mclk) disable iff (reset)
    (state_reg == FFP_ON && sense.over_temp && !sense.supply_ov_trip && !pulse_end)
    |=> state_reg == FFP_THERMAL)
    else $error("over-temperature not handled");
  chk_thermal_no_drive: assert property (@(posedge mclk) disable iff (reset)
    state_reg == FFP_THERMAL
    |-> !gate_drive_output)
    else $error("drive active in thermal shutdown");
  chk_thermal_hold: assert property (@(posedge mclk) disable iff (reset)
    (state_reg == FFP_THERMAL && !sense.supply_reset && !line_sync && !sense.supply_ov_trip &&
     !(sense.temp_recovered && sense.supply_turn_on && !sense.over_temp))
    |=> state_reg == FFP_THERMAL)
    else $error("thermal left without recovery");
  chk_thermal_recover: assert property (@(posedge mclk) disable iff (reset)
    (state_reg == FFP_THERMAL && sense.temp_recovered && sense.supply_turn_on &&
     !sense.over_temp && !sense.supply_ov_trip)
    |=> state_reg == FFP_OFF)
    else $error("thermal not left after recovery");
  chk_thermal_clear: assert property (@(posedge mclk) disable iff (reset)
    (state_reg == FFP_THERMAL && (sense.supply_reset || line_sync) && !sense.supply_ov_trip)
    |=> state_reg == FFP_OFF)
    else $error("thermal not cleared");
  chk_off_start: assert property (@(posedge mclk) disable iff (reset)
    (state_reg == FFP_OFF && sense.supply_turn_on && !sense.over_temp && !sense.supply_ov_trip)
    |=> state_reg == FFP_DEMAG)
    else $error("no power-up at turn-on");
  chk_off_wait: assert property (@(posedge mclk) disable iff (reset)
    (state_reg == FFP_OFF && !sense.supply_turn_on && !sense.supply_ov_trip)
    |=> state_reg == FFP_OFF)
    else $error("power-up without turn-on");
  chk_off_fault_hold: assert property (@(posedge mclk) disable iff (reset)
    (state_reg == FFP_OFF && sense.over_temp && !sense.supply_ov_trip)
    |=> state_reg == FFP_OFF)
    else $error("power-up with fault present");
  // Latched state exit and reset
  chk_latch_hold: assert property (@(posedge mclk) disable iff (reset)
    (state_reg == FFP_LATCHED && !clear_req)
    |=> state_reg == FFP_LATCHED)
    else $error("latch released without clear");
  chk_latch_clear: assert property (@(posedge mclk) disable iff (reset)
    (state_reg == FFP_LATCHED && clear_req)
    |=> state_reg == FFP_OFF)
    else $error("latch not released by clear");
  chk_latch_no_drive: assert property (@(posedge mclk) disable iff (reset)
    state_reg == FFP_LATCHED
    |-> !gate_drive_output)
    else $error("drive active while latched");
  chk_reset_state: assert property (@(posedge mclk)
    reset
    |=> state_reg == FFP_OFF && aoc_cnt_reg == 3'h0 && ov_cnt_reg == 2'h0 && status == '0)
    else $error("reset did not clear fault state");
endmodule // ffp_fault_ctrl

// ### verilog/ffp_pkg.sv
// Purpose: constants and types for the flyback fault sequencing logic
// Assumes: 40 MHz mclk, all comparator inputs asynchronous to mclk
// Notes:
// Overview of operation
// - Ignore abnormal overcurrent for 125 ns blanking.
// - Four consecutive tripped pulses latch the device.
// - Clean pulse clears abnormal overcurrent counter.
// - End on-period at 32 us maximum.
// - Armed demag input holds valley timeout disabled.
// - Armed demag blocks next pulse until disarmed.
// - Supply overvoltage stops drive, latches fault.
// - Three consecutive output overvoltage cycles latch.
// - Over-temperature gives non-latching shutdown.
// - Thermal restart needs hysteresis cleared, turn-on.
// - Supply reset or line removal clears thermal.
// - Restart at turn-on only when faults gone.
// - Latch leaves only on supply reset, discharge.
package ffp_pkg;
  localparam int unsigned CLK_PERIOD_PS      = 25000;
  localparam int unsigned SHORT_BLANK_NS     = 125;
  localparam int unsigned MAX_ON_US          = 32;
  localparam int unsigned VALLEY_TIMEOUT_US  = 6;
  // Least time rounds up, longest time rounds down
  localparam int unsigned SHORT_BLANK_CYC    =
    (SHORT_BLANK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned MAX_ON_CYC         = (MAX_ON_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned VALLEY_TIMEOUT_CYC = (VALLEY_TIMEOUT_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned TIMER_W            = 11;
  localparam logic [2:0]  AOC_LIMIT          = 3'h4;
  localparam logic [1:0]  OUT_OV_LIMIT       = 2'h3;
  localparam int unsigned NUM_SYNC           = 8;

  typedef enum {FFP_OFF, FFP_ON, FFP_DEMAG, FFP_LATCHED, FFP_THERMAL} ffp_state_t;

  // Comparator results as they arrive from the analog side
  typedef struct packed {
    logic aoc_trip;
    logic supply_ov_trip;
    logic out_ov_trip;
    logic over_temp;
    logic temp_recovered;
    logic demag_armed;
    logic supply_turn_on;
    logic supply_reset;
  } ffp_sense_t;

  // Fault flags reported outward
  typedef struct packed {
    logic latched;
    logic thermal;
    logic aoc_latch;
    logic supply_ov_latch;
    logic out_ov_latch;
  } ffp_status_t;
endpackage

// ### verilog/ffp_sync.sv
// Purpose: two flip-flop level synchroniser
// Assumes: input asynchronous to mclk
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
module ffp_sync (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_reg;
  logic sync_reg;
  logic meta_next;
  logic sync_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule // ffp_sync
